// >>> sgf_cond.sv
// branch condition evaluator
`timescale 1ns/1ps
module sgf_cond (
  // condition and flags
  input wire sgf_pkg::sgf_cond_type cond,
  input wire sgf_pkg::sgf_flags_type fl,
  // result
  output logic hit
);
  import sgf_pkg::*;
  always_comb begin
    case (cond)
      SGF_CND_ALWAYS: hit = 1'b1;
      // [RULE17] unsigned ge is carry
      SGF_CND_C, SGF_CND_UGE: hit = fl.c;
      // [RULE23] signed and unsigned compounds
      SGF_CND_GE: hit = ~(fl.n ^ fl.overflow_flag);
      SGF_CND_GT: hit = ~fl.z & ~(fl.n ^ fl.overflow_flag);
      SGF_CND_LE: hit = fl.z | (fl.n ^ fl.overflow_flag);
      SGF_CND_LT: hit = fl.n ^ fl.overflow_flag;
      SGF_CND_GTU: hit = fl.c & ~fl.z;
      SGF_CND_LEU: hit = ~fl.c | fl.z;
      // [RULE17] unsigned lt is no carry
      SGF_CND_NC, SGF_CND_ULT: hit = ~fl.c;
      // [RULE16] single flag tests
      SGF_CND_N: hit = fl.n;
      SGF_CND_NN: hit = ~fl.n;
      SGF_CND_NOV: hit = ~fl.overflow_flag;
      SGF_CND_NZ: hit = ~fl.z;
      SGF_CND_Z: hit = fl.z;
      SGF_CND_OVF: hit = fl.overflow_flag;
      // [RULE15] accumulator conditions
      SGF_CND_ACCA_OVF: hit = fl.acc_a_overflow;
      SGF_CND_ACCB_OVF: hit = fl.acc_b_overflow;
      SGF_CND_ACCA_SAT: hit = fl.acc_a_saturate;
      SGF_CND_ACCB_SAT: hit = fl.acc_b_saturate;
      default: hit = 1'b0;
    endcase
  end
endmodule // sgf_cond

// >>> sgf_core.sv
// stack guard, frame active flag, status flags and branch decision
// Notes on behaviour
// [RULE1] limit is 16 bits, resets to zero, bit 0 always zero
// [RULE2] checking starts at first word write to limit, stops only at reset
// [RULE3] checked stack address above limit raises stack error trap
// [RULE4] checked stack address wrapping past top of space traps
// [RULE5] stack pointer resets to 0x0800, or 0x1000 on large variant
// [RULE6] stack address below floor always traps
// [RULE7] stack pointer addresses never paged, low 64K only
// [RULE8] frame pointer paged only while frame active flag clear
// [RULE9] frame active flag is control bit 2, read only
// [RULE10] link sets frame active flag, unlink clears it
// [RULE11] calls stack flag in return address bit 0, then clear it
// [RULE12] returns reload flag from popped return address bit 0
// [RULE13] compares update flags only, write nothing
// [RULE14] branch taken only when its condition is true
// [RULE15] conditions cover signed, unsigned and accumulator flags
// [RULE16] single flag conditions test one flag, negated forms inverted
// [RULE17] unsigned ge equals carry, unsigned lt equals no carry
// [RULE18] compare and skip leaves all flags alone
// [RULE19] carry chained ops only clear zero, never set it
// [RULE20] chained sequence ands all zero tests
// [RULE21] push writes then adds two, pop subtracts two then reads
// [RULE22] call pushes low pc word then zero-extended upper seven bits
// [RULE23] compound conditions use the customary equations
// [RULE24] all stack faults drive one trap request
`timescale 1ns/1ps
module sgf_core #(
  parameter bit BIG_RESERVED = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // stack and frame operations
  input wire logic op_valid,
  input wire sgf_pkg::sgf_op_type op,
  input wire logic [22:0] op_pc,
  input wire logic [15:0] op_ret_word,
  // effective address checks
  input wire logic ea_valid,
  input wire logic ea_use_sp,
  input wire logic ea_use_fp,
  input wire logic [15:0] ea_addr,
  input wire logic ea_wrap,
  input wire logic [7:0] ea_page,
  // alu flag updates
  input wire logic alu_valid,
  input wire sgf_pkg::sgf_alu_type alu_kind,
  input wire sgf_pkg::sgf_flags_type alu_flags,
  input wire logic [15:0] alu_result,
  // branch requests
  input wire logic br_valid,
  input wire sgf_pkg::sgf_cond_type br_cond,
  // results
  output logic stack_trap,
  output logic busy,
  output logic [15:0] sp_value,
  output logic push_valid,
  output logic [15:0] push_addr,
  output logic [15:0] push_data,
  output logic phys_valid,
  output logic [23:0] phys_addr,
  output logic frame_active_flag,
  output sgf_pkg::sgf_flags_type flags,
  output logic br_done,
  output logic br_taken
);
  import sgf_pkg::*;

  localparam logic [15:0] FLOOR = BIG_RESERVED ? SGF_FLOOR_BIG : SGF_FLOOR_STD;

  logic [15:0] stack_limit_r;
  logic chk_en_r;
  logic [15:0] sp_r;
  logic frame_active_r;
  logic [6:0] pc_hi_r;
  sgf_state_type state_r;
  sgf_flags_type flags_r;
  logic trap_r;
  logic aw_have_r, w_have_r;
  logic [31:0] aw_addr_r, w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic push_valid_r, phys_valid_r, br_done_r, br_taken_r;
  logic [15:0] push_addr_r, push_data_r;
  logic [23:0] phys_addr_r;
  logic cond_hit;
  logic wr_fire, limit_sel, word_wr;
  logic op_go, chk_valid, chk_wrap;
  logic [15:0] chk_addr;

  // bus write: address and data may arrive in either order
  assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
  assign limit_sel = aw_addr_r[31:2] == SGF_LIMIT_OFS[31:2];
  assign word_wr = wr_fire & limit_sel & (&w_strb_r[1:0]);
  assign op_go = op_valid & (state_r == SGF_ST_IDLE);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= SGF_RESP_OK;
    end else begin
      if (s_axi_awvalid & ~aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        // control and status words exist but ignore writes
        bresp_r <= (limit_sel || aw_addr_r[31:2] == SGF_CTRL_OFS[31:2] ||
                    aw_addr_r[31:2] == SGF_STAT_OFS[31:2]) ? SGF_RESP_OK : SGF_RESP_ERR;
      end else if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // [RULE1] limit register, bit 0 held low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_limit_r <= SGF_LIMIT_RST;
    end else if (wr_fire & limit_sel) begin
      if (w_strb_r[0]) stack_limit_r[7:1] <= w_data_r[7:1];
      if (w_strb_r[1]) stack_limit_r[15:8] <= w_data_r[15:8];
    end
  end

  // [RULE2] sticky check enable; byte writes do not arm it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) chk_en_r <= 1'b0;
    else if (word_wr) chk_en_r <= 1'b1;
  end

  // bus read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= SGF_RESP_OK;
    end else if (s_axi_arvalid & ~rvalid_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= SGF_RESP_OK;
      rdata_r <= 32'h0000_0000;
      case (s_axi_araddr[31:2])
        SGF_LIMIT_OFS[31:2]: rdata_r[15:0] <= stack_limit_r;
        // [RULE9] flag visible at bit 2, never written
        SGF_CTRL_OFS[31:2]: rdata_r[SGF_FRAME_BIT] <= frame_active_r;
        SGF_STAT_OFS[31:2]: rdata_r[16:0] <= {chk_en_r, sp_r};
        default: rresp_r <= SGF_RESP_ERR;
      endcase
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // address under check: external stack use or own push/pop
  always_comb begin
    chk_valid = 1'b0;
    chk_addr = sp_r;
    chk_wrap = 1'b0;
    if (ea_valid & ea_use_sp) begin
      chk_valid = 1'b1;
      chk_addr = ea_addr;
      chk_wrap = ea_wrap;
    end else if (state_r == SGF_ST_CALL_HI ||
                 (op_go && (op == SGF_OP_PUSH || op == SGF_OP_CALL))) begin
      chk_valid = 1'b1;
      chk_wrap = sp_r == 16'hFFFE;
    end else if (op_go && op == SGF_OP_POP) begin
      chk_valid = 1'b1;
      chk_addr = sp_r - SGF_WORD_STEP;
      chk_wrap = sp_r < SGF_WORD_STEP;
    end else if (op_go && op == SGF_OP_RET) begin
      chk_valid = 1'b1;
      chk_addr = sp_r - SGF_CALL_STEP;
      chk_wrap = sp_r < SGF_CALL_STEP;
    end
  end

  // [RULE24] one trap, registered from the check cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) trap_r <= 1'b0;
    // [RULE3] [RULE4] [RULE6] limit, wrap, floor
    else trap_r <= chk_valid & ((chk_en_r & (chk_addr > stack_limit_r | chk_wrap)) |
                                chk_addr < FLOOR);
  end

  // [RULE5] stack pointer; [RULE21] post-add push, pre-sub pop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sp_r <= BIG_RESERVED ? SGF_FLOOR_BIG : SGF_FLOOR_STD;
      state_r <= SGF_ST_IDLE;
      pc_hi_r <= 7'h00;
    end else begin
      case (state_r)
        SGF_ST_IDLE: begin
          if (op_go) begin
            case (op)
              SGF_OP_PUSH: sp_r <= sp_r + SGF_WORD_STEP;
              SGF_OP_POP: sp_r <= sp_r - SGF_WORD_STEP;
              SGF_OP_CALL: begin
                sp_r <= sp_r + SGF_WORD_STEP;
                pc_hi_r <= op_pc[22:16];
                state_r <= SGF_ST_CALL_HI;
              end
              SGF_OP_RET: sp_r <= sp_r - SGF_CALL_STEP;
              default: sp_r <= sp_r;
            endcase
          end
        end
        SGF_ST_CALL_HI: begin
          sp_r <= sp_r + SGF_WORD_STEP;
          state_r <= SGF_ST_IDLE;
        end
        default: state_r <= SGF_ST_IDLE;
      endcase
    end
  end

  // [RULE22] low word with flag, then zero-extended upper bits
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      push_valid_r <= 1'b0;
      push_addr_r <= 16'h0000;
      push_data_r <= 16'h0000;
    end else begin
      push_valid_r <= 1'b0;
      push_addr_r <= sp_r;
      if (state_r == SGF_ST_CALL_HI) begin
        push_valid_r <= 1'b1;
        push_data_r <= {9'h000, pc_hi_r};
      end else if (op_go && op == SGF_OP_CALL) begin
        push_valid_r <= 1'b1;
        // [RULE11] flag replaces pc bit 0
        push_data_r <= {op_pc[15:1], frame_active_r};
      end
    end
  end

  // frame active flag, changed only by instructions
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_active_r <= 1'b0;
    end else if (state_r == SGF_ST_CALL_HI) begin
      // [RULE11] cleared once both words are out
      frame_active_r <= 1'b0;
    end else if (op_go) begin
      case (op)
        // [RULE10] link and unlink
        SGF_OP_LINK: frame_active_r <= 1'b1;
        SGF_OP_UNLINK: frame_active_r <= 1'b0;
        // [RULE12] reload from popped return word
        SGF_OP_RET: frame_active_r <= op_ret_word[0];
        default: frame_active_r <= frame_active_r;
      endcase
    end
  end

  // physical address; stack and locked frame never paged
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phys_valid_r <= 1'b0;
      phys_addr_r <= 24'h000000;
    end else begin
      phys_valid_r <= ea_valid;
      // [RULE7] [RULE8] low 64K for stack pointer and locked frame pointer, all others paged
      if (ea_use_sp | (ea_use_fp & frame_active_r)) phys_addr_r <= {SGF_LOW_PAGE, ea_addr};
      else phys_addr_r <= {ea_page, ea_addr};
    end
  end

  // status flags; compares arrive as plain or chained updates
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_r <= '0;
    end else if (alu_valid) begin
      case (alu_kind)
        // [RULE13] flags only, no destination here
        SGF_ALU_PLAIN: begin
          flags_r <= alu_flags;
          flags_r.z <= alu_result == 16'h0000;
        end
        // [RULE19] [RULE20] chained zero can only fall
        SGF_ALU_CARRY: begin
          flags_r <= alu_flags;
          flags_r.z <= flags_r.z & (alu_result == 16'h0000);
        end
        // [RULE18] skip compares touch nothing
        SGF_ALU_SKIP: flags_r <= flags_r;
        default: flags_r <= flags_r;
      endcase
    end
  end

  sgf_cond u_cond (
    .cond(br_cond),
    .fl(flags_r),
    .hit(cond_hit)
  );

  // [RULE14] branch decision
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      br_done_r <= 1'b0;
      br_taken_r <= 1'b0;
    end else begin
      br_done_r <= br_valid;
      br_taken_r <= br_valid & cond_hit;
    end
  end

  assign s_axi_awready = ~aw_have_r;
  assign s_axi_wready = ~w_have_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign stack_trap = trap_r;
  assign busy = state_r == SGF_ST_CALL_HI;
  assign sp_value = sp_r;
  assign push_valid = push_valid_r;
  assign push_addr = push_addr_r;
  assign push_data = push_data_r;
  assign phys_valid = phys_valid_r;
  assign phys_addr = phys_addr_r;
  assign frame_active_flag = frame_active_r;
  assign flags = flags_r;
  assign br_done = br_done_r;
  assign br_taken = br_taken_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_limit_lsb; stack_limit_r[0] == 1'b0; endproperty
  a_limit_lsb: assert property (p_limit_lsb) else $error("limit bit 0 set"); // [RULE1]
  property p_en_cause; $rose(chk_en_r) |-> $past(word_wr); endproperty
  a_en_cause: assert property (p_en_cause) else $error("check armed without word write"); // [RULE2]
  property p_en_keep; chk_en_r |=> chk_en_r; endproperty
  a_en_keep: assert property (p_en_keep) else $error("check disarmed"); // [RULE2]
  property p_over; chk_valid && chk_en_r && chk_addr > stack_limit_r |=> stack_trap; endproperty
  a_over: assert property (p_over) else $error("overflow missed"); // [RULE3]
  property p_under; chk_valid && chk_addr < FLOOR |=> stack_trap; endproperty
  a_under: assert property (p_under) else $error("underflow missed"); // [RULE6]
  property p_link; op_go && op == SGF_OP_LINK |=> frame_active_flag; endproperty
  a_link: assert property (p_link) else $error("link did not set flag"); // [RULE10]
  property p_call; op_go && op == SGF_OP_CALL |=> push_valid && push_data[0] == $past(frame_active_r)
    ##1 push_valid && push_data[15:7] == 9'h000 && !frame_active_flag; endproperty
  a_call: assert property (p_call) else $error("call stacking wrong"); // [RULE11]
  property p_ret; op_go && op == SGF_OP_RET |=> frame_active_flag == $past(op_ret_word[0]);
  endproperty
  a_ret: assert property (p_ret) else $error("return flag reload wrong"); // [RULE12]
  property p_skip; alu_valid && alu_kind == SGF_ALU_SKIP |=> $stable(flags); endproperty
  a_skip: assert property (p_skip) else $error("skip compare changed flags"); // [RULE18]
  property p_chain; alu_valid && alu_kind == SGF_ALU_CARRY |=> !$rose(flags.z); endproperty
  a_chain: assert property (p_chain) else $error("chained op set zero"); // [RULE19]
  property p_page; phys_valid && $past(ea_use_sp) |-> phys_addr[23:16] == SGF_LOW_PAGE;
  endproperty
  a_page: assert property (p_page) else $error("stack address paged"); // [RULE7]
  c_trap: cover property (chk_valid && chk_en_r ##1 stack_trap);
  c_call: cover property (op_go && op == SGF_OP_CALL ##2 op_go && op == SGF_OP_RET);
  c_chain: cover property (alu_valid && alu_kind == SGF_ALU_CARRY ##1 flags.z);
endmodule // sgf_core

// >>> sgf_pipe_model.sv
// pipeline-side partner model: issues ops, address checks, alu updates, branches
`timescale 1ns/1ps
module sgf_pipe_model (
  // clock
  input wire logic clk,
  // requests towards the core
  output logic op_valid,
  output sgf_pkg::sgf_op_type op,
  output logic [22:0] op_pc,
  output logic [15:0] op_ret_word,
  output logic ea_valid,
  output logic ea_use_sp,
  output logic ea_use_fp,
  output logic [15:0] ea_addr,
  output logic ea_wrap,
  output logic [7:0] ea_page,
  output logic alu_valid,
  output sgf_pkg::sgf_alu_type alu_kind,
  output sgf_pkg::sgf_flags_type alu_flags,
  output logic [15:0] alu_result,
  output logic br_valid,
  output sgf_pkg::sgf_cond_type br_cond
);
  import sgf_pkg::*;
  initial begin
    {op_valid, op_pc, op_ret_word, ea_valid, ea_use_sp, ea_use_fp} = '0;
    {ea_addr, ea_wrap, ea_page, alu_valid, alu_flags, alu_result, br_valid} = '0;
    op = SGF_OP_NONE;
    alu_kind = SGF_ALU_PLAIN;
    br_cond = SGF_CND_ALWAYS;
  end
  // payload scrambled after release so stale values never look valid
  task automatic do_op(input sgf_op_type o, input logic [22:0] pc, input logic [15:0] rw);
    @(posedge clk);
    op <= o;
    op_pc <= pc;
    op_ret_word <= rw;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    op_pc <= ~pc;
    op_ret_word <= ~rw;
    #1;
  endtask
  task automatic do_ea(input logic sp, input logic fp, input logic [15:0] a,
                       input logic w, input logic [7:0] pg);
    @(posedge clk);
    {ea_use_sp, ea_use_fp, ea_addr, ea_wrap, ea_page} <= {sp, fp, a, w, pg};
    ea_valid <= 1'b1;
    @(posedge clk);
    ea_valid <= 1'b0;
    ea_addr <= ~a;
    #1;
  endtask
  task automatic do_alu(input sgf_alu_type k, input sgf_flags_type f, input logic [15:0] r);
    @(posedge clk);
    alu_kind <= k;
    alu_flags <= f;
    alu_result <= r;
    alu_valid <= 1'b1;
    @(posedge clk);
    alu_valid <= 1'b0;
    alu_result <= ~r;
    #1;
  endtask
  task automatic do_br(input sgf_cond_type c);
    @(posedge clk);
    br_cond <= c;
    br_valid <= 1'b1;
    @(posedge clk);
    br_valid <= 1'b0;
    #1;
  endtask
endmodule // sgf_pipe_model

// >>> sgf_pkg.sv
// shared constants and types for the stack guard and flag logic
package sgf_pkg;
  localparam logic [31:0] SGF_LIMIT_OFS = 32'h0000_0000;
  localparam logic [31:0] SGF_CTRL_OFS = 32'h0000_0004;
  localparam logic [31:0] SGF_STAT_OFS = 32'h0000_0008;
  localparam logic [15:0] SGF_LIMIT_RST = 16'h0000;
  localparam logic [15:0] SGF_FLOOR_STD = 16'h0800;
  localparam logic [15:0] SGF_FLOOR_BIG = 16'h1000;
  localparam logic [15:0] SGF_WORD_STEP = 16'h0002;
  localparam logic [15:0] SGF_CALL_STEP = 16'h0004;
  localparam logic [7:0] SGF_LOW_PAGE = 8'h00;
  localparam int SGF_FRAME_BIT = 2;
  localparam logic [1:0] SGF_RESP_OK = 2'h0;
  localparam logic [1:0] SGF_RESP_ERR = 2'h2;
  typedef struct packed {
    logic acc_b_saturate;
    logic acc_a_saturate;
    logic acc_b_overflow;
    logic acc_a_overflow;
    logic z;
    logic overflow_flag;
    logic n;
    logic c;
  } sgf_flags_type;
  typedef enum logic [4:0] {
    SGF_CND_ALWAYS, SGF_CND_C, SGF_CND_GE, SGF_CND_UGE, SGF_CND_GT,
    SGF_CND_GTU, SGF_CND_LE, SGF_CND_LEU, SGF_CND_LT, SGF_CND_ULT,
    SGF_CND_N, SGF_CND_NC, SGF_CND_NN, SGF_CND_NOV, SGF_CND_NZ,
    SGF_CND_ACCA_OVF, SGF_CND_ACCB_OVF, SGF_CND_OVF, SGF_CND_ACCA_SAT, SGF_CND_ACCB_SAT,
    SGF_CND_Z
  } sgf_cond_type;
  typedef enum logic [1:0] {
    SGF_ALU_PLAIN, SGF_ALU_CARRY, SGF_ALU_SKIP
  } sgf_alu_type;
  typedef enum logic [2:0] {
    SGF_OP_NONE, SGF_OP_PUSH, SGF_OP_POP, SGF_OP_CALL,
    SGF_OP_RET, SGF_OP_LINK, SGF_OP_UNLINK
  } sgf_op_type;
  typedef enum logic {SGF_ST_IDLE, SGF_ST_CALL_HI} sgf_state_type;
endpackage

// >>> stack_guard_and_flag_logic_test.sv
// self-checking bench for the stack guard and flag core
`timescale 1ns/1ps
module stack_guard_and_flag_logic_test;
  import sgf_pkg::*;
  logic clk, sys_rst;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic op_valid, ea_valid, ea_use_sp, ea_use_fp, ea_wrap, alu_valid, br_valid;
  sgf_op_type op;
  logic [22:0] op_pc;
  logic [15:0] op_ret_word, ea_addr, alu_result, sp_value, push_addr, push_data;
  logic [7:0] ea_page;
  sgf_alu_type alu_kind;
  sgf_flags_type alu_flags, flags;
  sgf_cond_type br_cond;
  logic stack_trap, busy, push_valid, phys_valid, frame_active_flag, br_done, br_taken;
  logic [23:0] phys_addr;
  int err_count = 0;
  int comparisons = 0;
  sgf_core dut (.*);
  sgf_pipe_model pipe (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic wrap_up();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic aw_h, w_h, b_h;
    logic [1:0] r;
    b_h = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (b_h !== 1'b1) begin
      @(negedge clk);
      aw_h = s_axi_awvalid && s_axi_awready;
      w_h = s_axi_wvalid && s_axi_wready;
      b_h = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw_h) s_axi_awvalid <= 1'b0;
      if (w_h) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({b_h, r}, {1'b1, er});
  endtask
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] ed,
                        input logic [1:0] er);
    logic ar_h, r_h;
    logic [31:0] rd;
    logic [1:0] rr;
    r_h = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (r_h !== 1'b1) begin
      @(negedge clk);
      ar_h = s_axi_arvalid && s_axi_arready;
      r_h = s_axi_rvalid;
      {rd, rr} = {s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ar_h) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk({r_h, rd & m}, {1'b1, ed});
    chk(rr, er);
  endtask
  task automatic ea(input logic sp, input logic fp, input logic [15:0] a, input logic w,
                    input logic [7:0] pg, input logic et, input logic [23:0] ep);
    pipe.do_ea(sp, fp, a, w, pg);
    chk({stack_trap, phys_valid, phys_addr}, {et, 1'b1, ep});
  endtask
  function automatic logic cond_exp(input sgf_cond_type c, input sgf_flags_type f);
    case (c)
      SGF_CND_ALWAYS: return 1'b1;
      SGF_CND_C, SGF_CND_UGE: return f.c;
      SGF_CND_NC, SGF_CND_ULT: return !f.c;
      SGF_CND_GE: return f.n ~^ f.overflow_flag;
      SGF_CND_LT: return f.n ^ f.overflow_flag;
      SGF_CND_GT: return !f.z && (f.n ~^ f.overflow_flag);
      SGF_CND_LE: return f.z || (f.n ^ f.overflow_flag);
      SGF_CND_GTU: return f.c && !f.z;
      SGF_CND_LEU: return !f.c || f.z;
      SGF_CND_N: return f.n;
      SGF_CND_NN: return !f.n;
      SGF_CND_OVF: return f.overflow_flag;
      SGF_CND_NOV: return !f.overflow_flag;
      SGF_CND_Z: return f.z;
      SGF_CND_NZ: return !f.z;
      SGF_CND_ACCA_OVF: return f.acc_a_overflow;
      SGF_CND_ACCB_OVF: return f.acc_b_overflow;
      SGF_CND_ACCA_SAT: return f.acc_a_saturate;
      default: return f.acc_b_saturate;
    endcase
  endfunction
  task automatic scen_reset();
    chk({sp_value, frame_active_flag, flags}, {SGF_FLOOR_STD, 9'h000});
    axi_rd(SGF_LIMIT_OFS, 32'h0000_FFFF, 32'h0, SGF_RESP_OK);
    axi_rd(32'h0000_0010, 32'hFFFF_FFFF, 32'h0, SGF_RESP_ERR);
    axi_wr(32'h0000_0010, 32'h0, 4'hF, SGF_RESP_ERR);
  endtask
  task automatic scen_guard();
    ea(1'b1, 1'b0, 16'h07FE, 1'b0, 8'h5A, 1'b1, 24'h0007FE);
    ea(1'b1, 1'b0, 16'h0900, 1'b1, 8'h5A, 1'b0, 24'h000900);
    axi_wr(SGF_LIMIT_OFS, 32'h0000_0AFF, 4'h1, SGF_RESP_OK);
    ea(1'b1, 1'b0, 16'h0B00, 1'b0, 8'h00, 1'b0, 24'h000B00);
    axi_wr(SGF_LIMIT_OFS, 32'h0000_0A01, 4'hF, SGF_RESP_OK);
    axi_rd(SGF_LIMIT_OFS, 32'h0000_FFFF, 32'h0000_0A00, SGF_RESP_OK);
    ea(1'b1, 1'b0, 16'h0A00, 1'b0, 8'h00, 1'b0, 24'h000A00);
    ea(1'b1, 1'b0, 16'h0A02, 1'b0, 8'h00, 1'b1, 24'h000A02);
    ea(1'b1, 1'b0, 16'h0900, 1'b1, 8'h00, 1'b1, 24'h000900);
    ea(1'b0, 1'b1, 16'h0A02, 1'b0, 8'h5A, 1'b0, 24'h5A0A02);
    axi_wr(SGF_LIMIT_OFS, 32'h0000_FFFE, 4'hF, SGF_RESP_OK);
    ea(1'b1, 1'b0, 16'h0900, 1'b1, 8'h00, 1'b1, 24'h000900);
    axi_rd(SGF_STAT_OFS, 32'h0001_FFFF, 32'h0001_0800, SGF_RESP_OK);
  endtask
  // mid-run reset must disarm checking again
  task automatic scen_rearm();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    axi_rd(SGF_STAT_OFS, 32'h0001_FFFF, 32'h0000_0800, SGF_RESP_OK);
    ea(1'b1, 1'b0, 16'h0900, 1'b1, 8'h00, 1'b0, 24'h000900);
    axi_wr(SGF_LIMIT_OFS, 32'h0000_FFFE, 4'hF, SGF_RESP_OK);
  endtask
  task automatic scen_frame();
    pipe.do_op(SGF_OP_LINK, 23'h0, 16'h0);
    chk(frame_active_flag, 1'b1);
    axi_wr(SGF_CTRL_OFS, 32'h0, 4'hF, SGF_RESP_OK);
    axi_rd(SGF_CTRL_OFS, 32'h0000_0004, 32'h0000_0004, SGF_RESP_OK);
    ea(1'b0, 1'b1, 16'h0A00, 1'b0, 8'h5A, 1'b0, 24'h000A00);
    pipe.do_op(SGF_OP_CALL, 23'h3F_1234, 16'h0);
    chk({stack_trap, push_valid, busy, push_addr, push_data}, {3'h3, 32'h0800_1235});
    @(posedge clk);
    #1;
    chk({push_valid, busy, push_addr, push_data}, {2'h2, 32'h0802_003F});
    chk({sp_value, frame_active_flag}, {16'h0804, 1'b0});
    pipe.do_op(SGF_OP_RET, 23'h0, 16'h1235);
    chk({sp_value, frame_active_flag}, {16'h0800, 1'b1});
    pipe.do_op(SGF_OP_UNLINK, 23'h0, 16'h0);
    chk(frame_active_flag, 1'b0);
    pipe.do_op(SGF_OP_POP, 23'h0, 16'h0);
    chk({stack_trap, sp_value}, {1'b1, 16'h07FE});
    pipe.do_op(SGF_OP_PUSH, 23'h0, 16'h0);
    chk({stack_trap, sp_value}, {1'b1, 16'h0800});
  endtask
  task automatic scen_zero();
    pipe.do_alu(SGF_ALU_PLAIN, 8'h00, 16'h0000);
    chk(flags, 8'h08);
    pipe.do_alu(SGF_ALU_CARRY, 8'h08, 16'h0000);
    chk(flags, 8'h08);
    pipe.do_alu(SGF_ALU_CARRY, 8'h08, 16'h0005);
    chk(flags, 8'h00);
    pipe.do_alu(SGF_ALU_CARRY, 8'h08, 16'h0000);
    chk(flags, 8'h00);
    pipe.do_alu(SGF_ALU_SKIP, 8'hFF, 16'h0000);
    chk(flags, 8'h00);
  endtask
  task automatic scen_branch();
    sgf_flags_type f;
    for (int j = 0; j < 16; j++) begin
      f = {~4'(j), ~j[3], 3'(j)};
      pipe.do_alu(SGF_ALU_PLAIN, {~4'(j), j[3], 3'(j)}, {15'h0, j[3]});
      chk(flags, f);
      for (int k = 0; k < 21; k++) begin
        pipe.do_br(sgf_cond_type'(k));
        chk({br_done, br_taken}, {1'b1, cond_exp(sgf_cond_type'(k), f)});
      end
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    scen_reset();
    scen_guard();
    scen_rearm();
    scen_frame();
    scen_zero();
    scen_branch();
    wrap_up();
  end
  // watchdog well above the roughly eight hundred cycles needed
  initial begin
    #(20 * 20000);
    err_count++;
    wrap_up();
  end
endmodule // stack_guard_and_flag_logic_test
